// ---- servo_channel_cfg.svh ----
`ifndef SERVO_CHANNEL_CFG_SVH
`define SERVO_CHANNEL_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_INDEX_GATE_DEMUX 8'h00
`define OFS_OUTPUT_FORMAT 8'h04
`define OFS_OUTPUT_POLARITY 8'h08
`define OFS_PULSE_DIR_INVERT 8'h0c
`define OFS_FRAC_ENABLE 8'h10
`define OFS_GATED_INDEX_SEL 8'h14
`define OFS_CHANNEL_STATUS 8'h18
`define OFS_POSITION_WORD0 8'h1c
`define OFS_POSITION_WORD1 8'h20

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_GATE_LOW_LOW 0
`define BIT_DEMUX_ENABLE 1
`define BIT_POL_AB 0
`define BIT_POL_C 1
`define BIT_FMT_AB_DAC 0
`define BIT_FMT_C_PFM 1
`define BIT_STAT_INDEX 0
`define BIT_STAT_GATED 1
`define BIT_STAT_INVALID_DEMUX 2
`define BIT_STAT_HALL_LO 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_INDEX_GATE_DEMUX 2'h0
`define RST_OUTPUT_FORMAT 2'h0
`define RST_OUTPUT_POLARITY 2'h0
`define RST_PULSE_DIR_INVERT 1'h0
`define RST_FRAC_ENABLE 1'h0
`define RST_GATED_INDEX_SEL 1'h0

`endif

// ---- servo_channel_pkg.sv ----
package servo_channel_pkg;

	typedef enum logic [1:0] {
		FMT_PWM_PWM,
		FMT_DAC_PWM,
		FMT_PWM_PFM,
		FMT_DAC_PFM
	} output_format_e;

endpackage : servo_channel_pkg

// ---- servo_channel_index_output.sv ----
// Function
// - Two-bit gate/demux setting, values 0..3, zero after reset, demux bit overrides the gating bit.
// - Gated capture passes index only in high-high (bit0=0) or low-low (bit0=1).
// - Gated index is A&B&C for setting 0, ~A&~B&C for setting 1.
// - Demux bit clear: third channel is index only, no hall separation.
// - Demux bit set: third channel sampled per AB state, index plus three halls.
// - Settings 2 and 3 demultiplex and ignore the gating bit.
// - Status bit 2 flags invalid demux until all four AB states seen.
// - Format: 0 PWM/PWM, 1 DAC/PWM, 2 PWM/PULSE_FREQUENCY_OUTPUT, 3 DAC/PULSE_FREQUENCY_OUTPUT.
// - Polarity zero drives PWM on, pulse on and DAC ones high.
// - Direction output changes together with the pulse leading edge.
// - Inverted pulse: rising edge is trailing, pulse width gives direction set-up.
// - Direction low for positive command when invert is 0, high when 1.
// - Direction invert acts only with format 2 or 3.
// - Fractional enable resets to 0 (off); 1 enables hardware estimator.
// - Estimator computes a new fractional position every sample clock cycle.
// - Fractional count feeds capture when enabled.
// - Enabled: first two position words return fractional data instead of timers.
// - Gated index select 0 routes raw third channel to capture.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "servo_channel_cfg.svh"

module servo_channel_index_output #(
	parameter int TIMER_W = 16,
	parameter int FRAC_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic third_encoder_channel,
	input wire logic sample_tick,
	input wire logic pwm_a,
	input wire logic pwm_b,
	input wire logic pwm_c,
	input wire logic dac_a_bit,
	input wire logic dac_b_bit,
	input wire logic pulse_frequency_output,
	input wire logic cmd_negative,
	output logic out_a,
	output logic out_b,
	output logic out_c,
	output logic out_dir,
	output logic gated_index_signal,
	output logic [2:0] hall_state,
	output logic [FRAC_W-1:0] frac_count
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] filt;
		logic gi;
		logic gi_prev;
		logic [2:0] hall;
		logic dmx_index;
		logic [3:0] seen;
		logic [1:0] gate_ctl;
		logic [1:0] fmt;
		logic [1:0] pol;
		logic dir_inv;
		logic frac_en;
		logic gi_sel;
		logic ack;
		logic [31:0] rdat;
		logic oa;
		logic ob;
		logic oc;
		logic dir;
		logic pulse_prev;
		logic [TIMER_W-1:0] since;
		logic [TIMER_W-1:0] period;
		logic [FRAC_W-1:0] frac;
		logic [FRAC_W-1:0] cap_frac;
	} state_s;

	state_s st_q;
	state_s st_d;

	// Fraction of a count elapsed, saturated just below one count.
	function automatic logic [FRAC_W-1:0] frac_calc(input logic [TIMER_W-1:0] since,
		input logic [TIMER_W-1:0] period);
		logic [TIMER_W+FRAC_W-1:0] num;
		logic [TIMER_W+FRAC_W-1:0] quo;
		num = {since, {FRAC_W{1'b0}}};
		quo = '0;
		if (period == '0 || since >= period)
			quo = {(TIMER_W+FRAC_W){1'b1}};
		else
			quo = num / {{FRAC_W{1'b0}}, period};
		frac_calc = (quo > {{TIMER_W{1'b0}}, {FRAC_W{1'b1}}}) ? {FRAC_W{1'b1}} : quo[FRAC_W-1:0];
	endfunction : frac_calc

	logic bus_req;
	logic wr_lo;
	logic [1:0] ab;
	logic ab_moved;
	logic lead;
	logic gi_calc;
	logic [FRAC_W-1:0] frac_next;
	logic [31:0] status_word;
	servo_channel_pkg::output_format_e fmt_e;

	assign bus_req = cyc_i && stb_i && !st_q.ack;
	assign wr_lo = bus_req && we_i && sel_i[0];
	assign ab = st_q.filt[1:0];
	assign fmt_e = servo_channel_pkg::output_format_e'(st_q.fmt);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		// Inputs pass three stages; a change counts once stages two and three agree.
		st_d.s1 = {third_encoder_channel, enc_b, enc_a};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < 3; i++)
		begin
			if (st_q.s2[i] == st_q.s3[i])
				st_d.filt[i] = st_q.s3[i];
		end
		ab_moved = st_d.filt[1:0] != ab;

		// Third channel is demultiplexed by the settled AB state.
		if (st_q.gate_ctl[`BIT_DEMUX_ENABLE])
		begin
			unique case (ab)
				2'h0: st_d.dmx_index = st_q.filt[2];
				2'h1: st_d.hall[0] = st_q.filt[2];
				2'h3: st_d.hall[1] = st_q.filt[2];
				2'h2: st_d.hall[2] = st_q.filt[2];
			endcase
			st_d.seen = st_q.seen | (4'h1 << ab);
		end
		else
		begin
			st_d.dmx_index = st_q.filt[2];
		end

		// Capture index: raw, gated by one quadrature state, or demultiplexed.
		gi_calc = st_q.filt[2];
		if (st_q.gi_sel)
		begin
			if (st_q.gate_ctl[`BIT_DEMUX_ENABLE])
				gi_calc = st_q.dmx_index;
			else if (st_q.gate_ctl[`BIT_GATE_LOW_LOW])
				gi_calc = !ab[0] && !ab[1] && st_q.filt[2];
			else
				gi_calc = ab[0] && ab[1] && st_q.filt[2];
		end
		st_d.gi = gi_calc;
		st_d.gi_prev = st_q.gi;

		// Timers between quadrature edges feed the fractional estimate.
		if (ab_moved)
		begin
			st_d.period = st_q.since + TIMER_W'(1);
			st_d.since = '0;
		end
		else if (st_q.since != {TIMER_W{1'b1}})
		begin
			st_d.since = st_q.since + TIMER_W'(1);
		end
		frac_next = frac_calc(st_q.since, st_q.period);
		if (!st_q.frac_en)
			st_d.frac = '0;
		else if (sample_tick)
			st_d.frac = frac_next;
		if (st_q.gi && !st_q.gi_prev)
			st_d.cap_frac = st_q.frac;

		// Command outputs with format select and polarity.
		st_d.oa = (st_q.fmt[`BIT_FMT_AB_DAC] ? dac_a_bit : pwm_a) ^ st_q.pol[`BIT_POL_AB];
		st_d.ob = (st_q.fmt[`BIT_FMT_AB_DAC] ? dac_b_bit : pwm_b) ^ st_q.pol[`BIT_POL_AB];
		st_d.oc = (st_q.fmt[`BIT_FMT_C_PFM] ? pulse_frequency_output : pwm_c) ^ st_q.pol[`BIT_POL_C];
		st_d.pulse_prev = pulse_frequency_output;
		lead = pulse_frequency_output && !st_q.pulse_prev;
		// In formats 2 and 3 direction moves only with the pulse leading edge (else held low), so with the pulse inverted
		// the whole pulse width becomes set-up time before the rising edge.
		if (!(fmt_e == servo_channel_pkg::FMT_PWM_PFM || fmt_e == servo_channel_pkg::FMT_DAC_PFM))
			st_d.dir = 1'b0;
		else if (lead)
			st_d.dir = cmd_negative ^ st_q.dir_inv;

		// Register bus: one wait state, unmapped reads return zero.
		st_d.ack = bus_req;
		st_d.rdat = '0;
		if (wr_lo)
		begin
			unique case (adr_i)
				`OFS_INDEX_GATE_DEMUX: st_d.gate_ctl = dat_i[1:0];
				`OFS_OUTPUT_FORMAT: st_d.fmt = dat_i[1:0];
				`OFS_OUTPUT_POLARITY: st_d.pol = dat_i[1:0];
				`OFS_PULSE_DIR_INVERT: st_d.dir_inv = dat_i[0];
				`OFS_FRAC_ENABLE: st_d.frac_en = dat_i[0];
				`OFS_GATED_INDEX_SEL: st_d.gi_sel = dat_i[0];
				default: ;
			endcase
		end
		if (bus_req && !we_i)
		begin
			unique case (adr_i)
				`OFS_INDEX_GATE_DEMUX: st_d.rdat = {30'h0, st_q.gate_ctl};
				`OFS_OUTPUT_FORMAT: st_d.rdat = {30'h0, st_q.fmt};
				`OFS_OUTPUT_POLARITY: st_d.rdat = {30'h0, st_q.pol};
				`OFS_PULSE_DIR_INVERT: st_d.rdat = {31'h0, st_q.dir_inv};
				`OFS_FRAC_ENABLE: st_d.rdat = {31'h0, st_q.frac_en};
				`OFS_GATED_INDEX_SEL: st_d.rdat = {31'h0, st_q.gi_sel};
				`OFS_CHANNEL_STATUS: st_d.rdat = status_word;
				`OFS_POSITION_WORD0: st_d.rdat = st_q.frac_en ? 32'(st_q.frac) : 32'(st_q.period);
				`OFS_POSITION_WORD1: st_d.rdat = st_q.frac_en ? 32'(st_q.cap_frac) : 32'(st_q.since);
				default: st_d.rdat = '0;
			endcase
		end
	end

	always_comb
	begin
		status_word = '0;
		status_word[`BIT_STAT_INDEX] = st_q.dmx_index;
		status_word[`BIT_STAT_GATED] = st_q.gi;
		status_word[`BIT_STAT_INVALID_DEMUX] = st_q.gate_ctl[`BIT_DEMUX_ENABLE] && !(&st_q.seen);
		status_word[`BIT_STAT_HALL_LO +: 3] = st_q.hall;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.gate_ctl <= `RST_INDEX_GATE_DEMUX;
			st_q.fmt <= `RST_OUTPUT_FORMAT;
			st_q.pol <= `RST_OUTPUT_POLARITY;
			st_q.dir_inv <= `RST_PULSE_DIR_INVERT;
			st_q.frac_en <= `RST_FRAC_ENABLE;
			st_q.gi_sel <= `RST_GATED_INDEX_SEL;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign ack_o = st_q.ack;
	assign dat_o = st_q.rdat;
	assign out_a = st_q.oa;
	assign out_b = st_q.ob;
	assign out_c = st_q.oc;
	assign out_dir = st_q.dir;
	assign gated_index_signal = st_q.gi;
	assign hall_state = st_q.hall;
	assign frac_count = st_q.frac;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic stable_dir_cfg;
	assign stable_dir_cfg = (st_q.fmt == st_d.fmt) && (st_q.dir_inv == st_d.dir_inv);

	a_gate_high_high: assert property (st_q.gi_sel && st_q.gate_ctl == 2'h0 |=>
		st_q.gi == ($past(st_q.filt[0]) && $past(st_q.filt[1]) && $past(st_q.filt[2])))
		else $error("gated index differs from A and B and C");
	a_gate_low_low: assert property (st_q.gi_sel && st_q.gate_ctl == 2'h1 |=>
		st_q.gi == (!$past(st_q.filt[0]) && !$past(st_q.filt[1]) && $past(st_q.filt[2])))
		else $error("gated index differs from low-low gating");
	a_raw_index_path: assert property (!st_q.gi_sel |=> st_q.gi == $past(st_q.filt[2]))
		else $error("raw index not passed to capture");
	a_demux_ignores_gate: assert property (st_q.gi_sel && st_q.gate_ctl[1] |=>
		st_q.gi == $past(st_q.dmx_index))
		else $error("demux setting did not use demultiplexed index");
	a_invalid_demux_clear: assert property ($fell(status_word[2]) |-> st_q.seen == 4'hf || !st_q.gate_ctl[1])
		else $error("invalid demux cleared before all states seen");
	a_dir_lead_only: assert property (!lead && stable_dir_cfg && st_q.fmt[1] |=> $stable(st_q.dir))
		else $error("direction changed away from pulse leading edge");
	a_dir_idle_low: assert property (!st_q.fmt[1] |=> !out_dir)
		else $error("direction driven outside pulse format");
	a_plain_pwm_pol: assert property (st_q.fmt == 2'h0 && st_q.pol == 2'h0 |=>
		out_a == $past(pwm_a) && out_c == $past(pwm_c))
		else $error("non-inverted output not high true");
	a_frac_off_zero: assert property (!st_q.frac_en ##1 !st_q.frac_en |-> frac_count == '0)
		else $error("fractional count active while disabled");
	a_frac_per_tick: assert property (st_q.frac_en && sample_tick |=>
		frac_count == frac_calc($past(st_q.since), $past(st_q.period)))
		else $error("fractional estimate not refreshed on sample tick");
	a_bus_ack_once: assert property (ack_o |=> !ack_o)
		else $error("bus acknowledge held longer than one cycle");

	a_no_demux_index: assert property (!st_q.gate_ctl[1] |=>
		st_q.dmx_index == $past(st_q.filt[2]) && $stable(st_q.hall))
		else $error("third channel not used as plain index");
	a_demux_hall_pick: assert property (st_q.gate_ctl[1] && ab == 2'h1 |=>
		hall_state[0] == $past(st_q.filt[2]) && $stable(st_q.dmx_index))
		else $error("hall value not taken in its quadrature state");
	a_invalid_demux_set: assert property (st_q.gate_ctl[1] && st_q.seen != 4'hf |-> status_word[2])
		else $error("invalid demux not flagged before all states seen");
	a_dir_from_cmd: assert property (st_q.fmt[1] && lead |=>
		out_dir == ($past(cmd_negative) ^ $past(st_q.dir_inv)))
		else $error("direction level does not follow command sign");
	a_dac_pfm_pol: assert property (st_q.fmt == 2'h3 && st_q.pol == 2'h0 |=>
		out_a == $past(dac_a_bit) && out_b == $past(dac_b_bit) && out_c == $past(pulse_frequency_output))
		else $error("dac and pulse outputs not high true");
	a_cap_frac_latch: assert property (st_q.gi && !st_q.gi_prev |=>
		st_q.cap_frac == $past(st_q.frac))
		else $error("fractional count not captured at index");
	a_frac_word_read: assert property (bus_req && !we_i && st_q.frac_en &&
		adr_i == `OFS_POSITION_WORD0 |=> dat_o == 32'($past(st_q.frac)))
		else $error("position word does not return fractional count");
	a_timer_word_read: assert property (bus_req && !we_i && !st_q.frac_en &&
		adr_i == `OFS_POSITION_WORD0 |=> dat_o == 32'($past(st_q.period)))
		else $error("position word does not return timer while estimator is off");

	c_demux_all_seen: cover property (st_q.gate_ctl[1] && st_q.seen == 4'hf);
	c_pfm_lead: cover property (st_q.fmt[1] && lead ##1 $changed(out_dir));
	c_frac_read: cover property (st_q.frac_en && ack_o && frac_count != '0);
	c_gated_low_low: cover property (st_q.gi_sel && st_q.gate_ctl == 2'h1 && gated_index_signal);
	c_dac_outputs: cover property (st_q.fmt == 2'h3 && out_a && out_b);

endmodule : servo_channel_index_output

// ---- enc_model.sv ----
`timescale 1ns/1ns
module enc_model (
	input wire logic ref_clk,
	input wire logic powered,
	output logic enc_a,
	output logic enc_b,
	output logic chan_c
);
	logic [2:0] pins_q = 3'h0;
	// An encoder without supply pulls all three lines low.
	assign enc_a = powered & pins_q[0];
	assign enc_b = powered & pins_q[1];
	assign chan_c = powered & pins_q[2];
	task automatic put(input logic [1:0] ab, input logic c);
		@(posedge ref_clk);
		pins_q <= {c, ab};
		repeat (8) @(posedge ref_clk);
	endtask : put
endmodule : enc_model

// ---- tb_servo_channel_index_output.sv ----
`timescale 1ns/1ns
module tb_servo_channel_index_output;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic [7:0] adr_i = 8'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q, d, r;
	logic [3:0] sel_i = 4'h0;
	logic ack_o, enc_a, enc_b, third_encoder_channel, power = 1'h0;
	logic pwm_a = 1'h0, pwm_b = 1'h0, pwm_c = 1'h0, dac_a_bit = 1'h0, dac_b_bit = 1'h0;
	logic pulse_frequency_output = 1'h0, cmd_negative = 1'h0;
	logic out_a, out_b, out_c, out_dir, gated_index_signal, idx, dir_m, pulse_m, dinv;
	logic [2:0] hall_state, h;
	logic [1:0] fmt, pol, tick_q = 2'h0;
	logic [7:0] frac_count;
	int n_mismatch = 0;
	int cmp_count = 0;
	int wid [6] = '{2, 2, 2, 1, 1, 1};
	wire sample_tick = (tick_q == 2'h3);
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) tick_q <= tick_q + 2'h1;
	servo_channel_index_output dut (.ref_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
		.ack_o, .dat_o, .enc_a, .enc_b, .third_encoder_channel, .sample_tick, .pwm_a, .pwm_b, .pwm_c,
		.dac_a_bit, .dac_b_bit, .pulse_frequency_output, .cmd_negative, .out_a, .out_b, .out_c,
		.out_dir, .gated_index_signal, .hall_state, .frac_count);
	enc_model enc (.ref_clk, .powered(power), .enc_a, .enc_b, .chan_c(third_encoder_channel));
	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	function automatic void chk(string s, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endfunction : chk
	// Entered just after a rising edge; leaves one idle cycle behind.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		sel_i <= 4'hf;
		do
			@(posedge ref_clk);
		while (ack_o !== 1'h1 && ++n < 50);
		if (n >= 50)
			n_mismatch++;
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge ref_clk);
	endtask : wb
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		conclude();
	end
	// --------------------------------------------------------
	// Main sequence.
	// --------------------------------------------------------
	initial
	begin
		void'($urandom(74));
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++)
		begin
			wb(1'h0, 8'(4 * i), 32'h0, q);
			chk("reset value", 32'h0, q);
			d = $urandom();
			wb(1'h1, 8'(4 * i), d, q);
			wb(1'h0, 8'(4 * i), 32'h0, q);
			chk("readback", d & ((32'h1 << wid[i]) - 32'h1), q);
		end
		wb(1'h0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1'h1, 8'h14, 32'h1, q);
		wb(1'h1, 8'h00, 32'h3, q);
		wb(1'h0, 8'h18, 32'h0, q);
		chk("invalid demux", 32'h1, (q >> 2) & 32'h1);
		power <= 1'h1;
		h = 3'($urandom());
		idx = 1'($urandom());
		enc.put(2'h0, idx);
		enc.put(2'h1, h[0]);
		enc.put(2'h3, h[1]);
		enc.put(2'h2, h[2]);
		enc.put(2'h0, idx);
		chk("hall", 32'(h), 32'(hall_state));
		chk("demux index", 32'(idx), 32'(gated_index_signal));
		wb(1'h0, 8'h18, 32'h0, q);
		chk("status", 32'(h) << 4, q & 32'h74);
		for (int k = 0; k < 32; k++)
		begin
			wb(1'h1, 8'h14, 32'(k[4]), q);
			wb(1'h1, 8'h00, 32'(k[3]), q);
			enc.put(k[1:0], k[2]);
			d = k[4] ? (k[3] ? 32'(!k[0] && !k[1] && k[2]) : 32'(k[0] && k[1] && k[2])) : 32'(k[2]);
			chk("gated index", d, 32'(gated_index_signal));
		end
		dir_m = 1'h0;
		pulse_m = 1'h0;
		for (int k = 0; k < 64; k++)
		begin
			fmt = 2'($urandom());
			pol = 2'($urandom());
			pol = fmt[0] ? (pol & 2'h2) : pol;
			dinv = 1'($urandom());
			wb(1'h1, 8'h04, 32'(fmt), q);
			wb(1'h1, 8'h08, 32'(pol), q);
			wb(1'h1, 8'h0c, 32'(dinv), q);
			repeat (8)
			begin
				r = $urandom();
				{pwm_a, pwm_b, pwm_c, dac_a_bit, dac_b_bit, pulse_frequency_output, cmd_negative} <= r[6:0];
				if (fmt[1] && r[1] && !pulse_m)
					dir_m = r[0] ^ dinv;
				if (!fmt[1])
					dir_m = 1'h0;
				pulse_m = r[1];
				@(posedge ref_clk);
				@(negedge ref_clk);
				d = {28'h0, (fmt[0] ? r[3] : r[6]) ^ pol[0], (fmt[0] ? r[2] : r[5]) ^ pol[0],
					(fmt[1] ? r[1] : r[4]) ^ pol[1], dir_m};
				chk("outputs", d, {28'h0, out_a, out_b, out_c, out_dir});
				@(posedge ref_clk);
			end
		end
		wb(1'h1, 8'h10, 32'h0, q);
		chk("frac off", 32'h0, 32'(frac_count));
		// Each put moves the pins nine cycles after the last one, and the filter delays both alike.
		// The read is taken four cycles after the filtered edge of the second put.
		enc.put(2'h1, 1'h0);
		enc.put(2'h3, 1'h0);
		wb(1'h0, 8'h20, 32'h0, q);
		chk("timer since edge", 32'h4, q);
		wb(1'h0, 8'h1c, 32'h0, q);
		chk("timer period", 32'h9, q);
		// With the encoder at rest beyond one period the estimate saturates at all ones.
		wb(1'h1, 8'h10, 32'h1, q);
		repeat (4) @(posedge ref_clk);
		wb(1'h0, 8'h1c, 32'h0, q);
		chk("frac word", 32'hff, q);
		chk("frac count", 32'hff, 32'(frac_count));
		conclude();
	end
endmodule : tb_servo_channel_index_output
